// ### hw/tod_counter.sv
/*
 * Time-of-day block: a prescaled 64-bit clock count with latch, phase step
 * and pps capture, plus a microsecond tick counter with set and slew.
 * Registers sit behind an AXI4-Lite slave.
 * Assumes one core clock; the PPS pin is asynchronous to it.
 */
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module tod_counter #(
  parameter int PRESCALE_CYC = tod_pkg::PRESCALE_CYC,
  parameter int TICK_CYC     = tod_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  // pulse-per-second pin and its request
  input  wire logic        PPS_IN,
  output logic             PPS_IRQ,
  // axi4-lite write
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  localparam int UB = tod_pkg::UP_BITS;
  localparam int HB = tod_pkg::HW_BITS;

  logic [7:0]    aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          aw_held;
  logic          w_held;
  logic          wr_fire;
  logic          wr_map;
  logic          rd_fire;
  logic          rd_map;
  logic [31:0]   rd_mux;
  logic          pps_latch_en;
  logic [31:0]   pre_cnt;
  logic          pre_pulse;
  logic [HB-1:0] hw_cnt;
  logic [UB-1:0] upper;
  logic          hw_ovf;
  logic          step_fire;
  logic [UB-1:0] step_ext;
  logic [63:0]   latch_val;
  logic          sw_latch;
  logic          pps_latch;
  logic          pps_s1;
  logic          pps_s2;
  logic          pps_s3;
  logic          pps_lvl;
  logic          pps_rise;
  logic [31:0]   tick_cnt;
  logic          tick;
  logic [63:0]   tod;
  logic [31:0]   tod_hi_snap;
  logic [31:0]   set_lo;
  logic          set_fire;
  logic [31:0]   tick_us;
  logic [31:0]   tickadj;
  logic [31:0]   inc;
  logic          slew_fire;
  logic          slew_busy;
  logic          slew_neg;
  logic          slew_abort;
  logic [31:0]   slew_left;
  logic [31:0]   slew_mag;
  logic          div_busy;
  logic          div_done;
  logic [31:0]   div_q;
  logic          latch_from_pps;
  logic          pps_seen;
  logic          slew_err;
  tod_pkg::status_t status;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  // bus slave: address and data are taken in either order
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign wr_fire       = aw_held && w_held && !S_AXI_BVALID;
  assign rd_fire       = S_AXI_ARVALID && S_AXI_ARREADY;

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= tod_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_map ? tod_pkg::RESP_OKAY : tod_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_addr)
      tod_pkg::OFS_CTRL, tod_pkg::OFS_STATUS, tod_pkg::OFS_STEP,
      tod_pkg::OFS_CMD, tod_pkg::OFS_SET_LO, tod_pkg::OFS_SET_HI,
      tod_pkg::OFS_TICK, tod_pkg::OFS_TICKADJ,
      tod_pkg::OFS_SLEW: wr_map = 1'b1;
      default:           wr_map = 1'b0;
    endcase
  end

  always_comb begin
    rd_map = 1'b1;
    case (S_AXI_ARADDR)
      tod_pkg::OFS_CTRL:      rd_mux = {31'h0, pps_latch_en};
      tod_pkg::OFS_STATUS:    rd_mux = {28'h0, status};
      tod_pkg::OFS_LATCH_LO:  rd_mux = latch_val[31:0];
      tod_pkg::OFS_LATCH_HI:  rd_mux = latch_val[63:32];
      tod_pkg::OFS_TOD_LO:    rd_mux = tod[31:0];
      tod_pkg::OFS_TOD_HI:    rd_mux = tod_hi_snap;
      tod_pkg::OFS_SET_LO:    rd_mux = set_lo;
      tod_pkg::OFS_TICK:      rd_mux = tick_us;
      tod_pkg::OFS_TICKADJ:   rd_mux = tickadj;
      tod_pkg::OFS_SLEW_LEFT: rd_mux = slew_left;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_map = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= tod_pkg::RESP_OKAY;
      tod_hi_snap  <= 32'h0000_0000;
    end else begin
      if (rd_fire) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_mux;
        S_AXI_RRESP  <= rd_map ? tod_pkg::RESP_OKAY : tod_pkg::RESP_SLVERR;
        // the high word is frozen so a lo-then-hi read pair is coherent
        if (S_AXI_ARADDR == tod_pkg::OFS_TOD_LO) begin
          tod_hi_snap <= tod[63:32];
        end
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // write strobes into the block
  assign step_fire = wr_fire && aw_addr == tod_pkg::OFS_STEP;
  assign set_fire  = wr_fire && aw_addr == tod_pkg::OFS_SET_HI;
  assign slew_fire = wr_fire && aw_addr == tod_pkg::OFS_SLEW;
  assign sw_latch  = wr_fire && aw_addr == tod_pkg::OFS_CMD &&
                     w_strb[0] && w_data[tod_pkg::CMD_LATCH];
  assign step_ext  = UB'(signed'(w_data));

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pps_latch_en <= 1'b0;
      set_lo       <= 32'h0000_0000;
      tick_us      <= tod_pkg::TICK_US_RST;
      tickadj      <= tod_pkg::TICKADJ_RST;
    end else if (wr_fire) begin
      case (aw_addr)
        tod_pkg::OFS_CTRL: begin
          if (w_strb[0]) begin
            pps_latch_en <= w_data[tod_pkg::CTRL_PPS_LATCH];
          end
        end
        tod_pkg::OFS_SET_LO:  set_lo  <= merge(set_lo, w_data, w_strb);
        tod_pkg::OFS_TICK:    tick_us <= merge(tick_us, w_data, w_strb);
        tod_pkg::OFS_TICKADJ: tickadj <= merge(tickadj, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // prescaler and 64-bit clock count
  assign pre_pulse = pre_cnt == 32'(PRESCALE_CYC - 1);
  assign hw_ovf    = pre_pulse && hw_cnt == {HB{1'b1}};

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pre_cnt <= 32'h0000_0000;
      hw_cnt  <= '0;
      upper   <= '0;
    end else begin
      pre_cnt <= pre_pulse ? 32'h0000_0000 : pre_cnt + 32'h0000_0001;
      if (pre_pulse) begin
        hw_cnt <= hw_cnt + HB'(1);
      end
      // carry lands on the same edge as the low wrap; a step lands on the edge of its write
      upper <= upper + UB'(hw_ovf) + (step_fire ? step_ext : '0);
    end
  end

  // pps pin: three flops, a change counts once flops two and three agree
  assign pps_rise  = pps_s2 == pps_s3 && pps_s3 && !pps_lvl;
  assign pps_latch = pps_rise && pps_latch_en;

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pps_s1  <= 1'b0;
      pps_s2  <= 1'b0;
      pps_s3  <= 1'b0;
      pps_lvl <= 1'b0;
      PPS_IRQ <= 1'b0;
    end else begin
      pps_s1  <= PPS_IN;
      pps_s2  <= pps_s1;
      pps_s3  <= pps_s2;
      if (pps_s2 == pps_s3) begin
        pps_lvl <= pps_s3;
      end
      PPS_IRQ <= pps_rise;
    end
  end

  // both halves come from the same registered state, so no tearing
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      latch_val      <= 64'h0000_0000_0000_0000;
      latch_from_pps <= 1'b0;
    end else if (pps_latch) begin
      latch_val      <= {upper, HB'(0)} + {UB'(0), hw_cnt};
      latch_from_pps <= 1'b1;
    end else if (sw_latch) begin
      latch_val      <= {upper, HB'(0)} + {UB'(0), hw_cnt};
      latch_from_pps <= 1'b0;
    end
  end

  // sticky flags: a new event beats a clear in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pps_seen <= 1'b0;
      slew_err <= 1'b0;
    end else begin
      if (pps_rise) begin
        pps_seen <= 1'b1;
      end else if (wr_fire && aw_addr == tod_pkg::OFS_STATUS &&
                   w_strb[0] && w_data[tod_pkg::ST_PPS_SEEN]) begin
        pps_seen <= 1'b0;
      end
      if (slew_fire && slew_busy) begin
        slew_err <= 1'b1;
      end else if (wr_fire && aw_addr == tod_pkg::OFS_STATUS &&
                   w_strb[0] && w_data[tod_pkg::ST_SLEW_ERR]) begin
        slew_err <= 1'b0;
      end
    end
  end

  // tick counter and microsecond time of day
  assign tick = tick_cnt == 32'(TICK_CYC - 1);
  assign inc  = slew_left == 32'h0000_0000 ? tick_us :
                slew_neg ? tick_us - tickadj : tick_us + tickadj;

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      tick_cnt <= 32'h0000_0000;
      tod      <= 64'h0000_0000_0000_0000;
    end else begin
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      if (set_fire) begin
        tod <= {merge(tod[63:32], w_data, w_strb), set_lo};
      end else if (tick) begin
        tod <= tod + 64'(inc);
      end
    end
  end

  // slew: |delta| / tickadj ticks at the skewed rate
  assign slew_busy           = div_busy || slew_left != 32'h0000_0000;
  // one driver for the whole word; each flag is its own signal
  assign status = '{latch_pps:    latch_from_pps,
                    pps_seen:     pps_seen,
                    slew_err:     slew_err,
                    slew_pending: slew_busy};
  assign slew_mag            = w_data[31] ? 32'h0000_0000 - w_data : w_data;

  slew_divider #(
    .W(tod_pkg::DIV_BITS)
  ) u_div (
    .CORE_CLK(CORE_CLK),
    .RSTN    (RSTN),
    .START   (slew_fire && !slew_busy),
    .DIVIDEND(slew_mag),
    .DIVISOR (tickadj),
    .BUSY    (div_busy),
    .DONE    (div_done),
    .QUOTIENT(div_q)
  );

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      slew_left  <= 32'h0000_0000;
      slew_neg   <= 1'b0;
      slew_abort <= 1'b0;
    end else begin
      if (slew_fire && !slew_busy) begin
        slew_neg   <= w_data[31];
        slew_abort <= 1'b0;
      end else if (set_fire) begin
        slew_abort <= 1'b1;
      end
      if (set_fire) begin
        slew_left <= 32'h0000_0000;
      end else if (div_done && !slew_abort) begin
        slew_left <= div_q;
      end else if (tick && slew_left != 32'h0000_0000) begin
        slew_left <= slew_left - 32'h0000_0001;
      end
    end
  end

  sequence s_slew_req;
    slew_fire && !slew_busy && !set_fire;
  endsequence
  sequence s_div_result;
    ##[1:40] div_done;
  endsequence

  property p_hw_inc;
    @(posedge CORE_CLK) disable iff (!RSTN)
    pre_pulse |=> hw_cnt == $past(hw_cnt) + HB'(1);
  endproperty
  a_hw_inc: assert property (p_hw_inc)
    else $error("low counter did not advance on prescaler pulse");

  property p_carry;
    @(posedge CORE_CLK) disable iff (!RSTN)
    hw_ovf && !step_fire |=> upper == $past(upper) + UB'(1) && hw_cnt == '0;
  endproperty
  a_carry: assert property (p_carry)
    else $error("upper count missed the low counter carry");

  property p_latch;
    @(posedge CORE_CLK) disable iff (!RSTN)
    sw_latch && !pps_latch |=>
      latch_val == {$past(upper), $past(hw_cnt)} && !status.latch_pps;
  endproperty
  a_latch: assert property (p_latch)
    else $error("software latch captured a wrong count");

  property p_step;
    @(posedge CORE_CLK) disable iff (!RSTN)
    step_fire && !hw_ovf |=> upper == $past(upper) + $past(step_ext);
  endproperty
  a_step: assert property (p_step)
    else $error("phase step not added to upper count");

  property p_pps_irq;
    @(posedge CORE_CLK) disable iff (!RSTN)
    $rose(pps_s3) ##1 pps_s3 |-> PPS_IRQ ##1 !PPS_IRQ;
  endproperty
  a_pps_irq: assert property (p_pps_irq)
    else $error("pps edge gave no single request pulse");

  property p_pps_prio;
    @(posedge CORE_CLK) disable iff (!RSTN)
    pps_latch && sw_latch |=> status.latch_pps;
  endproperty
  a_pps_prio: assert property (p_pps_prio)
    else $error("software latch beat the pps latch");

  property p_tod_rate;
    @(posedge CORE_CLK) disable iff (!RSTN)
    tick && !set_fire |=> tod == $past(tod) + 64'($past(slew_left) == 0 ?
      $past(tick_us) : $past(slew_neg) ? $past(tick_us) - $past(tickadj) :
      $past(tick_us) + $past(tickadj));
  endproperty
  a_tod_rate: assert property (p_tod_rate)
    else $error("time of day stepped by a wrong increment");

  property p_slew_load;
    @(posedge CORE_CLK) disable iff (!RSTN)
    s_slew_req |-> s_div_result;
  endproperty
  a_slew_load: assert property (p_slew_load)
    else $error("slew duration not computed in time");

  property p_set;
    @(posedge CORE_CLK) disable iff (!RSTN)
    set_fire && w_strb == 4'hF |=>
      tod == {$past(w_data), $past(set_lo)} && slew_left == 0;
  endproperty
  a_set: assert property (p_set)
    else $error("set time did not load at once");

  property p_slew_err;
    @(posedge CORE_CLK) disable iff (!RSTN)
    slew_fire && slew_busy |=> status.slew_err && slew_left <= $past(slew_left);
  endproperty
  a_slew_err: assert property (p_slew_err)
    else $error("overlapping slew request not flagged");

  property p_pending;
    @(posedge CORE_CLK) disable iff (!RSTN)
    slew_left != 0 && !set_fire |-> status.slew_pending ##1
      slew_left == $past(slew_left) - 32'($past(tick));
  endproperty
  a_pending: assert property (p_pending)
    else $error("pending flag low while slew ticks remain");
endmodule

// ### hw/tod_pkg.sv
/*
 * Shared constants and types for the slewed time-of-day counter: clock
 * rates, derived cycle counts, register offsets, field positions, reset
 * values and the packed status word.
 * Assumes a single 200 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
package tod_pkg;
  // clock and derived rates
  localparam int CLK_HZ       = 200_000_000;
  localparam int COUNT_HZ     = 1000;
  localparam int PRESCALE_CYC = CLK_HZ / COUNT_HZ;
  localparam int TICK_HZ      = 100;
  localparam int TICK_CYC     = CLK_HZ / TICK_HZ;

  // counter geometry
  localparam int HW_BITS    = 16;
  localparam int CLOCK_BITS = 64;
  localparam int UP_BITS    = CLOCK_BITS - HW_BITS;
  localparam int DIV_BITS   = 32;

  // reset values
  localparam logic [31:0] TICK_US_RST = 32'h0000_2710;
  localparam logic [31:0] TICKADJ_RST = 32'h0000_0005;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_LATCH_LO  = 8'h08;
  localparam logic [7:0] OFS_LATCH_HI  = 8'h0C;
  localparam logic [7:0] OFS_STEP      = 8'h10;
  localparam logic [7:0] OFS_CMD       = 8'h14;
  localparam logic [7:0] OFS_TOD_LO    = 8'h18;
  localparam logic [7:0] OFS_TOD_HI    = 8'h1C;
  localparam logic [7:0] OFS_SET_LO    = 8'h20;
  localparam logic [7:0] OFS_SET_HI    = 8'h24;
  localparam logic [7:0] OFS_TICK      = 8'h28;
  localparam logic [7:0] OFS_TICKADJ   = 8'h2C;
  localparam logic [7:0] OFS_SLEW      = 8'h30;
  localparam logic [7:0] OFS_SLEW_LEFT = 8'h34;

  // field positions
  localparam int CTRL_PPS_LATCH = 0;
  localparam int CMD_LATCH      = 0;
  localparam int ST_PENDING     = 0;
  localparam int ST_SLEW_ERR    = 1;
  localparam int ST_PPS_SEEN    = 2;
  localparam int ST_LATCH_PPS   = 3;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic latch_pps;
    logic pps_seen;
    logic slew_err;
    logic slew_pending;
  } status_t;
endpackage

// ### hw/slew_divider.sv
/*
 * Sequential restoring divider: turns a slew amount and a slew delta into
 * a count of ticks.  One quotient bit per clock, so a division takes
 * W cycles after start.
 * Assumes start is only raised while busy is low.
 */
`timescale 1ns/1ps
module slew_divider #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         CORE_CLK,
  input  wire logic         RSTN,
  // request
  input  wire logic         START,
  input  wire logic [W-1:0] DIVIDEND,
  input  wire logic [W-1:0] DIVISOR,
  // result
  output logic              BUSY,
  output logic              DONE,
  output logic [W-1:0]      QUOTIENT
);
  logic [W-1:0] rem;
  logic [W-1:0] dvs;
  logic [W-1:0] quo;
  logic [7:0]   bits_left;
  logic [W:0]   trial;

  assign trial = {rem, quo[W-1]} - {1'b0, dvs};

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      rem       <= '0;
      dvs       <= '0;
      quo       <= '0;
      bits_left <= 8'h00;
      BUSY      <= 1'b0;
      DONE      <= 1'b0;
      QUOTIENT  <= '0;
    end else begin
      DONE <= 1'b0;
      if (START) begin
        rem       <= '0;
        dvs       <= DIVISOR;
        quo       <= DIVIDEND;
        bits_left <= 8'(W);
        BUSY      <= 1'b1;
      end else if (BUSY) begin
        if (!trial[W]) begin
          rem <= trial[W-1:0];
          quo <= {quo[W-2:0], 1'b1};
        end else begin
          rem <= {rem[W-2:0], quo[W-1]};
          quo <= {quo[W-2:0], 1'b0};
        end
        bits_left <= bits_left - 8'h01;
        if (bits_left == 8'h01) begin
          BUSY <= 1'b0;
          DONE <= 1'b1;
          // a zero delta would never end a slew, so it yields no slew
          if (dvs == '0) begin
            QUOTIENT <= '0;
          end else begin
            QUOTIENT <= !trial[W] ? {quo[W-2:0], 1'b1} : {quo[W-2:0], 1'b0};
          end
        end
      end
    end
  end
endmodule

// ### tb/pps_source.sv
/*
 * External second-pulse reference: one FIRE strobe gives a clean
 * pulse on the pps pin that is long enough to pass a synchroniser.
 * Assumes FIRE is a single-cycle strobe in the core clock domain.
 */
`timescale 1ns/1ps
module pps_source (
  // clock
  input  wire logic CORE_CLK,
  // request and pin
  input  wire logic FIRE,
  output logic      PPS_IN
);
  // starts idle: the model has no reset of its own
  logic [3:0] width = 4'h0;

  // a wide pulse, so the synchroniser cannot miss the rising edge
  always_ff @(posedge CORE_CLK) begin
    if (FIRE) begin
      width <= 4'hA;
    end else if (width != 4'h0) begin
      width <= width - 4'h1;
    end
  end

  assign PPS_IN = (width != 4'h0);
endmodule

// ### tb/test_tod_counter.sv
/*
 * Register-level test of the time-of-day block over AXI4-Lite, with
 * the pps reference model on the pin.
 * Assumes shortened counts: prescaler 4 cycles, tick 50 cycles.
 */
`timescale 1ns/1ps
module test_tod_counter;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        fire = 1'b0;
  logic        pps;
  logic        irq;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, v, v2, v3;
  int          err_count = 0;
  int          n_compared = 0;
  int          irq_n = 0;
  int          k;

  always #2.5 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;

  pps_source pps_ref (.CORE_CLK(clk), .FIRE(fire), .PPS_IN(pps));

  tod_counter #(.PRESCALE_CYC(4), .TICK_CYC(50)) uut (
    .CORE_CLK(clk), .RSTN(rstn), .PPS_IN(pps), .PPS_IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));

  task report_and_stop;
    $display("compared %0d wrong %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task hang(input string nm);
    err_count++;
    $display("wrong value %s expected answer seen none", nm);
    report_and_stop();
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // address and data go out together; each drops once its ready is seen
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w, ok;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 0;
    w = 0;
    ok = 0;
    for (int i = 0; i < 100 && !ok; i++) begin
      @(posedge clk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        r = bresp;
        ok = 1;
      end
    end
    if (!ok) hang("write");
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    bit ar, ok;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar = 0;
    ok = 0;
    for (int i = 0; i < 100 && !ok; i++) begin
      @(posedge clk);
      if (!ar && arready === 1'b1) begin
        ar = 1;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        v = rdata;
        r = rresp;
        ok = 1;
      end
    end
    if (!ok) hang("read");
    rready <= 1'b0;
  endtask

  // polls the pending flag: the tick count is still zero while dividing
  task wait_slew;
    for (k = 0; k < 40; k++) begin
      rd(tod_pkg::OFS_STATUS);
      if (v[0] === 1'b0) break;
      repeat (20) @(posedge clk);
    end
    if (k == 40) hang("slew end");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd(tod_pkg::OFS_TICK);
    chk("tick reset", tod_pkg::TICK_US_RST, v);
    rd(tod_pkg::OFS_TICKADJ);
    chk("tickadj reset", tod_pkg::TICKADJ_RST, v);
    rd(tod_pkg::OFS_STATUS);
    chk("status reset", 32'h0, v);
    rd(8'h3C);
    chk_resp("unmapped read", tod_pkg::RESP_SLVERR, r);
    chk("unmapped data", 32'h0, v);
    wr(8'h3C, 32'h1);
    chk_resp("unmapped write", tod_pkg::RESP_SLVERR, r);
    rd(tod_pkg::OFS_STEP);
    chk_resp("write-only read", tod_pkg::RESP_SLVERR, r);
    // counting rate, then phase steps of both signs
    wr(tod_pkg::OFS_CMD, 32'h1);
    rd(tod_pkg::OFS_LATCH_LO);
    v2 = v;
    repeat (400) @(posedge clk);
    wr(tod_pkg::OFS_CMD, 32'h1);
    rd(tod_pkg::OFS_LATCH_LO);
    chk("count rate", 32'h1, {31'h0, (v - v2) >= 100 && (v - v2) <= 104});
    wr(tod_pkg::OFS_STEP, 32'h3);
    wr(tod_pkg::OFS_STEP, 32'hFFFF_FFFF);
    wr(tod_pkg::OFS_CMD, 32'h1);
    rd(tod_pkg::OFS_LATCH_LO);
    chk("stepped upper", 32'h2, {16'h0, v[31:16]});
    v3 = v;
    rd(tod_pkg::OFS_LATCH_HI);
    chk("latch high", 32'h0, v);
    // pps pulse with direct latch enabled
    wr(tod_pkg::OFS_CTRL, 32'h1);
    v2 = irq_n;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (20) @(posedge clk);
    chk("irq pulses", v2 + 1, irq_n);
    rd(tod_pkg::OFS_STATUS);
    chk("pps flags", 32'hC, v & 32'hC);
    rd(tod_pkg::OFS_LATCH_LO);
    chk("pps latch later", 32'h1, {31'h0, v > v3});
    wr(tod_pkg::OFS_STATUS, 32'h4);
    wr(tod_pkg::OFS_CMD, 32'h1);
    rd(tod_pkg::OFS_STATUS);
    chk("flags after cmd latch", 32'h0, v & 32'hC);
    // slews on a 1000 us tick with the precise 3 us delta
    wr(tod_pkg::OFS_TICK, 32'd1000);
    wr(tod_pkg::OFS_TICKADJ, 32'd3);
    wr(tod_pkg::OFS_SET_LO, 32'd7);
    wr(tod_pkg::OFS_SET_HI, 32'h0);
    rd(tod_pkg::OFS_TOD_LO);
    chk("tod after set", 32'd7, v % 32'd1000);
    wr(tod_pkg::OFS_SLEW, 32'd30);
    rd(tod_pkg::OFS_STATUS);
    chk("pending", 32'h1, v & 32'h1);
    wr(tod_pkg::OFS_SLEW, 32'd3);
    chk_resp("overlap resp", tod_pkg::RESP_OKAY, r);
    rd(tod_pkg::OFS_STATUS);
    chk("overlap flag", 32'h2, v & 32'h2);
    wr(tod_pkg::OFS_STATUS, 32'h2);
    repeat (40) @(posedge clk);
    rd(tod_pkg::OFS_SLEW_LEFT);
    chk("ticks left", 32'h1, {31'h0, v == 32'd9 || v == 32'd10});
    wait_slew();
    rd(tod_pkg::OFS_STATUS);
    chk("pending done", 32'h0, v & 32'h3);
    rd(tod_pkg::OFS_TOD_LO);
    chk("fast slew", 32'd37, v % 32'd1000);
    wr(tod_pkg::OFS_SET_HI, 32'h0);
    wr(tod_pkg::OFS_SLEW, 32'hFFFF_FFFA);
    wait_slew();
    rd(tod_pkg::OFS_TOD_LO);
    chk("slow slew", 32'd1, v % 32'd1000);
    // a set in mid-slew leaves the plain rate
    wr(tod_pkg::OFS_SLEW, 32'd30);
    wr(tod_pkg::OFS_SET_HI, 32'h0);
    repeat (50) @(posedge clk);
    rd(tod_pkg::OFS_SLEW_LEFT);
    chk("set cancels slew", 32'h0, v);
    rd(tod_pkg::OFS_STATUS);
    chk("set clears pending", 32'h0, v & 32'h1);
    report_and_stop();
  end
endmodule
